// [inc/tsz_pkg.sv]
// Operation
// - Select 00/01/11 gives controller 1/2/3
// - Select 10 defers to data-link source field
// - Only controller 1 drives framing data link
// - Twenty-four control registers, timeslot 0 first
// - Suppression 00 sends octet unchanged
// - Suppression 01 stuffs bit 7 on zero
// - Alternate mode stuffs bit 8, signaling bit 7
// - Data-service mode sends 0x98 in place of a zero octet
package tsz_pkg;

  // ****************************************************************
  // Register map: register indexes, byte address is four times these
  // ****************************************************************
  localparam logic [11:0] CTRL_IDX   = 12'h300;  // Timeslot 0 control
  localparam logic [11:0] CTRL_LAST  = 12'h317;  // Timeslot 23 control
  localparam logic [11:0] DLSEL_IDX  = 12'h10A;  // Signaling and data-link select
  localparam logic [11:0] STATUS_IDX = 12'h318;  // Block status
  localparam int          TS_COUNT   = 24;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] CTRL_RST  = 8'h80;
  localparam logic [7:0] DLSEL_RST = 8'h00;
  localparam int MSEL_LO  = 6;
  localparam int ZS_LO    = 4;
  localparam int DLSRC_LO = 2;
  localparam int ST_FULL  = 7;
  localparam int ST_OUTV  = 6;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [1:0] MSEL_C1  = 2'h0;
  localparam logic [1:0] MSEL_C2  = 2'h1;
  localparam logic [1:0] MSEL_DL  = 2'h2;
  localparam logic [1:0] MSEL_C3  = 2'h3;
  localparam logic [1:0] ZS_NONE  = 2'h0;
  localparam logic [1:0] ZS_B7    = 2'h1;
  localparam logic [1:0] ZS_ALT   = 2'h2;
  localparam logic [1:0] ZS_DDS   = 2'h3;
  localparam logic [1:0] SRC_PCM  = 2'h0;
  localparam logic [1:0] SRC_C1   = 2'h1;
  localparam logic [1:0] SRC_C2   = 2'h2;
  localparam logic [1:0] SRC_C3   = 2'h3;
  localparam logic [7:0] DDS_CODE = 8'h98;

  // ****************************************************************
  // Buffering
  // ****************************************************************
  localparam int FIFO_W     = 15;  // {source, timeslot, octet}
  localparam int FIFO_DEPTH = 16;

endpackage : tsz_pkg

// [inc/tsz_fifo_if.sv]
`timescale 1ns/1ps
// Push and pop sides of the octet buffer
interface tsz_fifo_if #(
  parameter int W = 15
);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface : tsz_fifo_if

// [rtl/tsz_fifo.sv]
`timescale 1ns/1ps
module tsz_fifo
  import tsz_pkg::*;
#(
  parameter int W     = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic   clock,
  input  wire logic   resetn,
  tsz_fifo_if.fifo    q
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  // Handshakes use the registered flags so full and empty are honest
  assign push = q.push_valid && q.push_ready;
  assign pop  = q.pop_valid && q.pop_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign q.pop_data = mem[rd_ptr];

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  // Pointers, level and flags
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      q.push_ready <= 1'b0;
      q.pop_valid  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count        <= next_count;
      q.push_ready <= (next_count != (AW+1)'(DEPTH));  // Refuse when full
      q.pop_valid  <= (next_count != '0);
    end
  end

endmodule : tsz_fifo

// [rtl/tsz_timeslot_tx.sv]
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module tsz_timeslot_tx
  import tsz_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Octet stream in, one octet per timeslot
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [4:0]  in_ts,
  input  wire logic        in_sig_frame,
  input  wire logic        in_sig_bit,
  input  wire logic [7:0]  in_pcm,
  input  wire logic [23:0] in_msg,
  // Octet stream out
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [7:0]       out_data,
  output logic [4:0]       out_ts,
  output logic [1:0]       out_src,
  // Framing data link bit
  input  wire logic        fdl_strobe,
  input  wire logic [2:0]  msg_fdl_bit,
  output logic             fdl_bit
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [7:0]  ctrl_reg [TS_COUNT];
  logic [7:0]  dlsel_reg;
  logic [4:0]  last_ts;
  logic        wr_pend;
  logic [11:0] wr_idx;
  logic [11:0] ap_idx;
  logic        ap_hit;
  logic        ap_ctrl;
  logic [7:0]  rd_val;

  assign ap_hit  = hsel && hready && htrans[1];
  assign ap_idx  = haddr[13:2];
  assign ap_ctrl = (ap_idx >= CTRL_IDX) && (ap_idx <= CTRL_LAST) && (haddr[31:14] == '0);

  // Read value, forwarding a write still in its data phase
  always_comb begin
    rd_val = 8'h00;
    if (haddr[31:14] == '0) begin
      if (ap_ctrl) begin
        rd_val = ctrl_reg[5'(ap_idx - CTRL_IDX)];
      end else if (ap_idx == DLSEL_IDX) begin
        rd_val = dlsel_reg;
      end else if (ap_idx == STATUS_IDX) begin
        rd_val = {!in_ready, out_valid, 1'b0, last_ts};
      end
    end
    // Only mapped, writable places forward; an unmapped write still reads zero
    if (wr_pend && wr_idx == ap_idx
        && (ap_ctrl || (ap_idx == DLSEL_IDX && haddr[31:14] == '0))) begin
      rd_val = hwdata[7:0];  // Avoids a stale read right after a write
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Address phase capture; unmapped reads return zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= ap_hit && hwrite && (haddr[31:14] == '0);
      wr_idx  <= ap_idx;
      if (ap_hit && !hwrite) begin
        hrdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // One control register per timeslot, plus the data-link select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < TS_COUNT; i++) begin
        ctrl_reg[i] <= CTRL_RST;
      end
      dlsel_reg <= DLSEL_RST;
    end else if (wr_pend) begin
      if (wr_idx >= CTRL_IDX && wr_idx <= CTRL_LAST) begin
        ctrl_reg[5'(wr_idx - CTRL_IDX)] <= hwdata[7:0];
      end else if (wr_idx == DLSEL_IDX) begin
        dlsel_reg <= hwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Source selection and zero code suppression
  // ****************************************************************
  logic       ts_ok;
  logic [1:0] msel;
  logic [1:0] zsel;
  logic [1:0] src;
  logic [7:0] sel_oct;
  logic [7:0] sup_oct;
  logic       fire;

  assign ts_ok = (in_ts < 5'(TS_COUNT));
  assign fire  = in_valid && in_ready;

  // Looked up per octet, so a new setting acts on the next occurrence
  always_comb begin
    msel    = ts_ok ? ctrl_reg[in_ts][MSEL_LO+:2] : MSEL_DL;
    zsel    = ts_ok ? ctrl_reg[in_ts][ZS_LO+:2] : ZS_NONE;
    src     = SRC_PCM;
    sel_oct = in_pcm;
    case (msel)
      MSEL_C1: src = SRC_C1;
      MSEL_C2: src = SRC_C2;
      MSEL_C3: src = SRC_C3;
      MSEL_DL: src = ts_ok ? dlsel_reg[DLSRC_LO+:2] : SRC_PCM;
      default: src = SRC_PCM;
    endcase
    case (src)
      SRC_C1:  sel_oct = in_msg[7:0];
      SRC_C2:  sel_oct = in_msg[15:8];
      SRC_C3:  sel_oct = in_msg[23:16];
      default: sel_oct = in_pcm;
    endcase
    sup_oct = sel_oct;
    if (sel_oct == 8'h00) begin
      case (zsel)
        ZS_B7: sup_oct[1] = 1'b1;
        ZS_ALT: begin
          if (!in_sig_frame) begin
            sup_oct[0] = 1'b1;
          end else if (!in_sig_bit) begin
            sup_oct[1] = 1'b1;
          end
        end
        ZS_DDS: sup_oct = DDS_CODE;
        default: sup_oct = sel_oct;
      endcase
    end
  end

  // ****************************************************************
  // Buffer and output stage
  // ****************************************************************
  tsz_fifo_if #(.W(FIFO_W)) fq ();

  tsz_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock  (clock),
    .resetn (resetn),
    .q      (fq)
  );

  // Back-pressure reaches the source through the buffer's full flag
  assign fq.push_valid = in_valid;
  assign fq.push_data  = {src, in_ts, sup_oct};
  assign fq.pop_ready  = !out_valid || out_ready;
  assign in_ready      = fq.push_ready;

  // Output register keeps every output on a flip-flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_ts    <= 5'h00;
      out_src   <= SRC_PCM;
    end else if (fq.pop_ready) begin
      out_valid <= fq.pop_valid;
      if (fq.pop_valid) begin
        {out_src, out_ts, out_data} <= fq.pop_data;
      end
    end
  end

  // Status: last timeslot accepted
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_ts <= 5'h00;
    end else if (fire) begin
      last_ts <= in_ts;
    end
  end

  // Framing data link bit: other controllers are never heard here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fdl_bit <= 1'b0;
    end else if (fdl_strobe) begin
      fdl_bit <= msg_fdl_bit[0];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sel_ctrl: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && msel == MSEL_C2 |-> fq.push_data[14:13] == SRC_C2
      && (in_msg[15:8] != 8'h00 -> fq.push_data[7:0] == in_msg[15:8]))
    else $error("controller 2 select not honoured");

  a_dl_source: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && msel == MSEL_DL |-> fq.push_data[14:13] == dlsel_reg[3:2])
    else $error("data-link source field ignored");

  a_fdl_owner: assert property (@(posedge clock) disable iff (!resetn)
    fdl_strobe |=> fdl_bit == $past(msg_fdl_bit[0]))
    else $error("framing bit not from controller 1");

  a_reg_write: assert property (@(posedge clock) disable iff (!resetn)
    wr_pend && wr_idx == CTRL_LAST |=> ctrl_reg[TS_COUNT-1] == $past(hwdata[7:0]))
    else $error("timeslot 23 register not written");

  a_no_suppress: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && zsel == ZS_NONE |-> fq.push_data[7:0] == sel_oct)
    else $error("octet altered with suppression off");

  a_b7_zero: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && zsel == ZS_B7 && sel_oct == 8'h00 |-> fq.push_data[7:0] == 8'h02)
    else $error("bit 7 stuffing wrong");

  a_alt_stuff: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && zsel == ZS_ALT && sel_oct == 8'h00 |-> fq.push_data[7:0] ==
      (!in_sig_frame ? 8'h01 : (!in_sig_bit ? 8'h02 : 8'h00)))
    else $error("alternate stuffing wrong");

  a_dds_code: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && ctrl_reg[in_ts][5:4] == 2'h3 && sel_oct == 8'h00
      |-> fq.push_data[7:0] == 8'h98)
    else $error("data-service code missing");

  a_mode_codes: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && ctrl_reg[in_ts][5:4] == 2'h2 && sel_oct == 8'h00 && !in_sig_frame
      |-> fq.push_data[7:0] == 8'h01)
    else $error("mode code 10 not alternate stuffing");

  a_live_cfg: assert property (@(posedge clock) disable iff (!resetn)
    wr_pend && wr_idx >= CTRL_IDX && wr_idx <= CTRL_LAST
      ##1 fire && ts_ok && 12'(in_ts) + CTRL_IDX == $past(wr_idx)
      |-> msel == $past(hwdata[7:6]) && zsel == $past(hwdata[5:4]))
    else $error("new setting not used on next octet");

  a_sel_c1: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && msel == MSEL_C1 |-> fq.push_data[14:13] == SRC_C1
      && (in_msg[7:0] != 8'h00 -> fq.push_data[7:0] == in_msg[7:0]))
    else $error("controller 1 select not honoured");

  a_sel_c3: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && msel == MSEL_C3 |-> fq.push_data[14:13] == SRC_C3
      && (in_msg[23:16] != 8'h00 -> fq.push_data[7:0] == in_msg[23:16]))
    else $error("controller 3 select not honoured");

  a_dl_pcm: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && msel == MSEL_DL && dlsel_reg[3:2] == SRC_PCM && zsel == ZS_NONE
      |-> fq.push_data[14:13] == SRC_PCM && fq.push_data[7:0] == in_pcm)
    else $error("data-link field 00 does not pass the octet");

  a_fdl_hold: assert property (@(posedge clock) disable iff (!resetn)
    !fdl_strobe |=> $stable(fdl_bit))
    else $error("framing bit moved without a strobe");

  a_reg_first: assert property (@(posedge clock) disable iff (!resetn)
    wr_pend && wr_idx == CTRL_IDX |=> ctrl_reg[0] == $past(hwdata[7:0]))
    else $error("timeslot 0 register not written");

  a_unmapped_rd: assert property (@(posedge clock) disable iff (!resetn)
    ap_hit && !hwrite && !ap_ctrl && ap_idx != DLSEL_IDX && ap_idx != STATUS_IDX
      |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_ts_range: assert property (@(posedge clock) disable iff (!resetn)
    fire && !ts_ok |-> fq.push_data[14:13] == SRC_PCM && fq.push_data[7:0] == in_pcm)
    else $error("timeslot beyond 23 altered");

  a_out_hold: assert property (@(posedge clock) disable iff (!resetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_ts)
      && $stable(out_src))
    else $error("held octet changed before it was taken");

  a_b7_nonzero: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && zsel == ZS_B7 && sel_oct != 8'h00 |-> fq.push_data[7:0] == sel_oct)
    else $error("bit 7 stuffing touched a nonzero octet");

  a_dds_nonzero: assert property (@(posedge clock) disable iff (!resetn)
    fire && ts_ok && zsel == ZS_DDS && sel_oct != 8'h00 |-> fq.push_data[7:0] == sel_oct)
    else $error("data-service code replaced a nonzero octet");

endmodule : tsz_timeslot_tx

// [bench/tsz_sink_model.sv]
`timescale 1ns/1ps
// Far-end terminal: takes transmitted octets and may hold off
module tsz_sink_model
  import tsz_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       stall,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic [4:0] out_ts,
  input  wire logic [1:0] out_src,
  output logic            out_ready
);
  logic [FIFO_W-1:0] got[$];

  // Ready moves just after an edge, so the octet it takes is the settled one
  always @(posedge clock) begin
    if (out_valid && out_ready)
      got.push_back({out_src, out_ts, out_data});
    out_ready <= !stall;
  end
endmodule : tsz_sink_model

// [bench/tsz_timeslot_tx_tb.sv]
`timescale 1ns/1ps
module tsz_timeslot_tx_tb
  import tsz_pkg::*;
;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [4:0]  ts;
    logic        sf;
    logic        sb;
    logic [7:0]  pcm;
    logic [23:0] msg;
    logic [1:0]  src;
    logic [7:0]  data;
  } tsz_row_s;

  logic        clock, resetn, hsel, hwrite, hreadyout, hresp, in_valid, in_ready;
  logic        in_sig_frame, in_sig_bit, out_valid, out_ready, fdl_strobe, fdl_bit, stall;
  logic [1:0]  htrans, out_src;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [4:0]  in_ts, out_ts;
  logic [7:0]  in_pcm, out_data;
  logic [23:0] in_msg;
  logic [2:0]  msg_fdl_bit;
  int          mismatches, tests_run, n, k;

  // Plain cases: control value, octet in, expected source and octet out
  tsz_row_s rows [14] = '{
    '{8'h00, 5'h00, 1'h0, 1'h0, 8'h55, 24'h03_0201, 2'h1, 8'h01},
    '{8'h40, 5'h01, 1'h0, 1'h0, 8'h55, 24'h03_0201, 2'h2, 8'h02},
    '{8'hC0, 5'h02, 1'h0, 1'h0, 8'h55, 24'h03_0201, 2'h3, 8'h03},
    '{8'h80, 5'h03, 1'h0, 1'h0, 8'h55, 24'h03_0201, 2'h0, 8'h55},
    '{8'h80, 5'h04, 1'h0, 1'h0, 8'h00, 24'h00_0000, 2'h0, 8'h00},
    '{8'h90, 5'h05, 1'h0, 1'h0, 8'h00, 24'h00_0000, 2'h0, 8'h02},
    '{8'h90, 5'h06, 1'h0, 1'h0, 8'h01, 24'h00_0000, 2'h0, 8'h01},
    '{8'hA0, 5'h07, 1'h0, 1'h0, 8'h00, 24'h00_0000, 2'h0, 8'h01},
    '{8'hA0, 5'h08, 1'h1, 1'h0, 8'h00, 24'h00_0000, 2'h0, 8'h02},
    '{8'hA0, 5'h09, 1'h1, 1'h1, 8'h00, 24'h00_0000, 2'h0, 8'h00},
    '{8'hB0, 5'h0A, 1'h0, 1'h0, 8'h00, 24'h00_0000, 2'h0, 8'h98},
    '{8'hB0, 5'h0C, 1'h0, 1'h0, 8'h5A, 24'h00_0000, 2'h0, 8'h5A},
    '{8'h30, 5'h17, 1'h0, 1'h0, 8'h55, 24'h03_0200, 2'h1, 8'h98},
    '{8'h00, 5'h18, 1'h0, 1'h0, 8'h00, 24'h03_0201, 2'h0, 8'h00}
  };

  always #2 clock = ~clock;

  tsz_timeslot_tx i_dut (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .in_valid, .in_ready,
    .in_ts, .in_sig_frame, .in_sig_bit, .in_pcm, .in_msg, .out_valid, .out_ready,
    .out_data, .out_ts, .out_src, .fdl_strobe, .msg_fdl_bit, .fdl_bit);

  tsz_sink_model snk (.clock, .stall, .out_valid, .out_data, .out_ts, .out_src,
    .out_ready);

  // ****************************************************************
  // Bus, stream and compare tasks
  // ****************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One single word transfer; waits for hready in both phases
  task ahb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Leaves valid high so that back-to-back octets never toggle it
  task send(input logic [4:0] ts, input logic sf, input logic sb, input logic [7:0] pcm,
            input logic [23:0] msg);
    in_valid <= 1'b1;
    in_ts <= ts;
    in_sig_frame <= sf;
    in_sig_bit <= sb;
    in_pcm <= pcm;
    in_msg <= msg;
    do @(posedge clock); while (in_ready !== 1'b1);
  endtask : send

  task expect_out(input logic [14:0] exp);
    for (n = 0; n < 60 && snk.got.size() == 0; n++)
      @(posedge clock);
    if (snk.got.size() == 0)
      snk.got.push_back('x);
    chk({17'h0, snk.got.pop_front()}, {17'h0, exp}, "octet");
  endtask : expect_out

  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Watchdog after 10000 cycles; the whole sequence needs well under that
  initial begin
    #40000;
    mismatches++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {clock, resetn, hsel, hwrite, in_valid, in_sig_frame, in_sig_bit} = '0;
    {fdl_strobe, stall, htrans, haddr, hwdata, in_ts, in_pcm, in_msg, msg_fdl_bit} = '0;
    {mismatches, tests_run} = '0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    // Reset values, unmapped place, response code
    ahb(1'b0, CTRL_IDX, 32'h0);
    chk(rd, 32'h0000_0080, "ctrl 0 reset");
    ahb(1'b0, CTRL_LAST, 32'h0);
    chk(rd, 32'h0000_0080, "ctrl 23 reset");
    ahb(1'b0, DLSEL_IDX, 32'h0);
    chk(rd, 32'h0000_0000, "dl select reset");
    ahb(1'b1, 12'h319, 32'h0000_00FF);
    ahb(1'b0, 12'h319, 32'h0);
    chk(rd, 32'h0000_0000, "unmapped");
    chk({31'h0, hresp}, 32'h0, "hresp");
    foreach (rows[i]) begin
      if (rows[i].ts < 5'h18)
        ahb(1'b1, CTRL_IDX + 12'(rows[i].ts), {24'h0, rows[i].ctrl});
      send(rows[i].ts, rows[i].sf, rows[i].sb, rows[i].pcm, rows[i].msg);
      in_valid <= 1'b0;
      expect_out({rows[i].src, rows[i].ts, rows[i].data});
    end
    ahb(1'b0, CTRL_IDX + 12'h00A, 32'h0);
    chk(rd, 32'h0000_00B0, "ctrl 10 readback");
    // Data-link source field picks each controller in turn
    ahb(1'b1, CTRL_IDX + 12'h00B, 32'h0000_0080);
    for (int s = 1; s < 4; s++) begin
      ahb(1'b1, DLSEL_IDX, {28'h0, 2'(s), 2'h0});
      send(5'h0B, 1'h0, 1'h0, 8'h55, 24'h03_0201);
      in_valid <= 1'b0;
      expect_out({2'(s), 5'h0B, 8'(s)});
    end
    // A changed setting applies to the next octet of that timeslot
    ahb(1'b1, CTRL_IDX + 12'h005, 32'h0);
    send(5'h05, 1'h0, 1'h0, 8'h55, 24'h00_0000);
    in_valid <= 1'b0;
    expect_out({2'h1, 5'h05, 8'h00});
    // Far end stalls: fill the buffer until refused, then drain it
    stall <= 1'b1;
    repeat (2) @(posedge clock);
    k = 0;
    send(5'h1F, 1'h0, 1'h0, 8'h01, 24'h00_0000);
    repeat (24) begin
      k++;
      in_pcm <= 8'(k + 1);
      do @(posedge clock); while (in_ready !== 1'b1 && n++ < 8);
      n = 0;
      if (in_ready !== 1'b1)
        break;
    end
    in_valid <= 1'b0;
    chk({31'h0, in_ready}, 32'h0, "refused when full");
    // The buffer holds its full depth and the output register one more
    chk(32'(k), 32'(FIFO_DEPTH + 1), "octets held");
    ahb(1'b0, STATUS_IDX, 32'h0);
    chk({31'h0, rd[ST_FULL]}, 32'h1, "status full");
    stall <= 1'b0;
    for (int j = 0; j < k; j++)
      expect_out({2'h0, 5'h1F, 8'(j + 1)});
    ahb(1'b0, STATUS_IDX, 32'h0);
    chk({30'h0, rd[ST_FULL], rd[ST_OUTV]}, 32'h0, "drained");
    // Framing data link follows controller 1 only, one strobe at a time
    msg_fdl_bit <= 3'h1;
    fdl_strobe <= 1'b1;
    @(posedge clock);
    fdl_strobe <= 1'b0;
    @(posedge clock);
    chk({31'h0, fdl_bit}, 32'h1, "fdl from ctrl 1");
    msg_fdl_bit <= 3'h6;
    fdl_strobe <= 1'b1;
    @(posedge clock);
    fdl_strobe <= 1'b0;
    msg_fdl_bit <= 3'h1;
    @(posedge clock);
    chk({31'h0, fdl_bit}, 32'h0, "fdl ignores ctrl 2 and 3");
    repeat (2) @(posedge clock);
    chk({31'h0, fdl_bit}, 32'h0, "fdl holds");
    // Mid-run reset: hreadyout and in_ready drop, control 10 and the data-link select read back their reset values
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    chk({30'h0, hreadyout, in_ready}, 32'h0, "outputs in reset");
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    ahb(1'b0, CTRL_IDX + 12'h00A, 32'h0);
    chk(rd, 32'h0000_0080, "ctrl 10 after reset");
    ahb(1'b0, DLSEL_IDX, 32'h0);
    chk(rd, 32'h0000_0000, "dl select after reset");
    wrap_up();
  end
endmodule : tsz_timeslot_tx_tb
